/* bench/sam_bank_chk.sv */
// Purpose: port checker for sam_bank
// Assumes: one clock, synchronous resets
// Notes:   cfg_q shadows bits 0..5 from host write cycles
`timescale 1ns/1ps
`default_nettype none
module sam_bank_chk (
  // clock and resets
  input wire logic             clock_i,
  input wire logic             srst_i,
  input wire logic             master_reset_pin_i,
  // host pins
  input wire logic             strb_n_i,
  input wire logic             rd_wr_i,
  input wire logic             reg_sel_i,
  input wire logic [15:0]      data_i,
  input wire logic             sync_i,
  input wire logic             sync_oe_n_o,
  input wire logic             bus_select_pin_i,
  // bus side
  input wire sam_pkg::sam_rx_t rx_a_i,
  input wire sam_pkg::sam_rx_t rx_b_i,
  input wire sam_pkg::sam_tx_t tx_o,
  input wire logic             tx_enable_a_o,
  input wire logic             tx_enable_b_o,
  input wire logic             word_ready_a_o,
  input wire logic             word_ready_b_o,
  input wire logic             error_o
);
  import sam_pkg::*;
  logic       strb_q;
  logic [5:0] cfg_q;
  logic [1:0] age;
  wire logic  fall = strb_q & ~strb_n_i;
  wire logic  ok   = age == 2'h3;
  // shadow config; age lets the registered enables settle first
  always_ff @(posedge clock_i) begin
    strb_q <= strb_n_i | srst_i | master_reset_pin_i;
    if (srst_i || master_reset_pin_i) begin
      cfg_q <= CFG_RESET;
      age   <= 2'h0;
    end else if (fall && !rd_wr_i && reg_sel_i) begin
      cfg_q <= data_i[5:0];
      age   <= 2'h0;
    end else if (!ok) begin
      age <= age + 2'h1;
    end
  end
  // ****************
  // properties
  // ****************
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i || master_reset_pin_i);
  sequence s_take; fall && !rd_wr_i && !reg_sel_i; endsequence
  sequence s_load;
    tx_o.load && tx_o.word == $past(data_i) && tx_o.cmd_sync == $past(sync_i | cfg_q[4])
      && tx_o.bus_b == $past(bus_select_pin_i | cfg_q[5]) ##1 !tx_o.load;
  endsequence
  property p_tx;    s_take |=> s_load; endproperty
  property p_txa;   ok |-> tx_enable_a_o == !cfg_q[0]; endproperty
  property p_txb;   ok |-> tx_enable_b_o == !cfg_q[1]; endproperty
  property p_rxoff; ok && !cfg_q[2] && rx_a_i.valid |=> !$rose(word_ready_a_o); endproperty
  property p_rdya;  ok && cfg_q[2] && rx_a_i.valid |=> word_ready_a_o; endproperty
  property p_start; ok && cfg_q[2] && rx_a_i.start && !rx_a_i.valid |=> !word_ready_a_o; endproperty
  property p_err;   ok && cfg_q[2] && rx_a_i.err |=> error_o; endproperty
  property p_rdyb;  ok && cfg_q[3] && rx_b_i.valid |=> word_ready_b_o; endproperty
  property p_soe;   !sync_oe_n_o |-> rd_wr_i && !reg_sel_i; endproperty
  a_tx: assert property (p_tx) else $error("bad transmit request");
  a_txa: assert property (p_txa) else $error("bus A enable wrong");
  a_txb: assert property (p_txb) else $error("bus B enable wrong");
  a_rxoff: assert property (p_rxoff) else $error("disabled bus A heard");
  a_rdya: assert property (p_rdya) else $error("bus A ready missing");
  a_start: assert property (p_start) else $error("start kept ready");
  a_err: assert property (p_err) else $error("fault not flagged");
  a_rdyb: assert property (p_rdyb) else $error("bus B ready missing");
  a_soe: assert property (p_soe) else $error("sync pin driven");
endmodule // sam_bank_chk
bind sam_bank sam_bank_chk u_chk (
  .clock_i(clock_i), .srst_i(srst_i), .master_reset_pin_i(master_reset_pin_i), .strb_n_i(strb_n_i),
  .rd_wr_i(rd_wr_i), .reg_sel_i(reg_sel_i), .data_i(data_i), .sync_i(sync_i), .sync_oe_n_o(sync_oe_n_o),
  .bus_select_pin_i(bus_select_pin_i), .rx_a_i(rx_a_i), .rx_b_i(rx_b_i), .tx_o(tx_o),
  .tx_enable_a_o(tx_enable_a_o), .tx_enable_b_o(tx_enable_b_o), .word_ready_a_o(word_ready_a_o),
  .word_ready_b_o(word_ready_b_o), .error_o(error_o)
);
`default_nettype wire

/* bench/sam_host_model.sv */
// Purpose: 16-bit host on the strobed port
// Assumes: one edge of strobe high between cycles
// Notes:   released data and sync lines fall to the pull-down
`timescale 1ns/1ps
`default_nettype none
module sam_host_model (
  // clock
  input  wire logic        clock_i,
  // pins toward the device
  output logic             strb_n_o,
  output logic             rd_wr_o,
  output logic             reg_sel_o,
  output logic [15:0]      data_o,
  output logic             sync_o,
  // read answer
  input  wire logic [15:0] rdata_i,
  input  wire logic        rsync_i
);
  initial begin
    strb_n_o  = 1'b1;
    rd_wr_o   = 1'b1;
    reg_sel_o = 1'b0;
    data_o    = 16'h0000;
    sync_o    = 1'b0;
  end
  // write cycle; reg_sel high picks the status word
  task automatic wr(input logic rs, input logic [15:0] d, input logic s);
    @(posedge clock_i);
    strb_n_o  <= 1'b0;
    rd_wr_o   <= 1'b0;
    reg_sel_o <= rs;
    data_o    <= d;
    sync_o    <= s;
    repeat (2) @(posedge clock_i);
    strb_n_o <= 1'b1;
    @(posedge clock_i);
    data_o  <= 16'h0000;
    sync_o  <= 1'b0;
    rd_wr_o <= 1'b1;
  endtask
  // read cycle; word taken before the strobe is released
  task automatic rd(input logic rs, output logic [15:0] d, output logic s);
    @(posedge clock_i);
    strb_n_o  <= 1'b0;
    rd_wr_o   <= 1'b1;
    reg_sel_o <= rs;
    repeat (3) @(posedge clock_i);
    d = rdata_i;
    s = rsync_i;
    strb_n_o <= 1'b1;
    repeat (3) @(posedge clock_i);
    #1;
  endtask
endmodule // sam_host_model
`default_nettype wire

/* bench/testbench.sv */
// Purpose: self-checking bench for sam_bank
// Assumes: host model drives the strobed port
// Notes:   bench drives decoder reports and pins
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sam_pkg::*;
  logic        clk, srst, mr, sel, s, t, sa;
  logic [15:0] v, w;
  sam_rx_t     rx_a, rx_b;
  int          failures, n_compared, cyc;
  int unsigned seed_v;
  wire logic        strb_n, rd_wr, reg_sel, hsync, soe_n, sync_o, doe_n, txa, txb, rdya, rdyb, err;
  wire logic [15:0] hdata, dout;
  wire sam_tx_t     tx;
  // sync pin: device drives only while its enable is low
  wire logic        sync_pin = soe_n ? hsync : sync_o;
  sam_host_model host (.clock_i(clk), .strb_n_o(strb_n), .rd_wr_o(rd_wr), .reg_sel_o(reg_sel),
    .data_o(hdata), .sync_o(hsync), .rdata_i(doe_n ? 16'h0000 : dout), .rsync_i(sync_pin));
  sam_bank uut (.clock_i(clk), .srst_i(srst), .master_reset_pin_i(mr), .strb_n_i(strb_n), .rd_wr_i(rd_wr),
    .reg_sel_i(reg_sel), .data_i(hdata), .data_o(dout), .data_oe_n_o(doe_n), .sync_i(sync_pin),
    .sync_o(sync_o), .sync_oe_n_o(soe_n), .bus_select_pin_i(sel), .rx_a_i(rx_a), .rx_b_i(rx_b), .tx_o(tx),
    .tx_enable_a_o(txa), .tx_enable_b_o(txb), .word_ready_a_o(rdya), .word_ready_b_o(rdyb), .error_o(err));
  initial clk = 1'b0;
  always #25 clk = ~clk;
  // ****************
  // helpers
  // ****************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] stat_w(input logic [5:0] c, input logic [3:0] a, input logic [3:0] b);
    return {1'b0, b, a, 1'b0, c};
  endfunction
  // one decoder pulse; word lines wander once dropped
  task automatic pulse(input logic b, input logic [4:0] f, input logic [15:0] d);
    @(posedge clk);
    if (b) rx_b <= {f, d};
    else rx_a <= {f, d};
    @(posedge clk);
    rx_a <= {5'h00, ~d};
    rx_b <= {5'h00, ~d};
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // hang guard, well above the run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    {srst, mr, sel, rx_a, rx_b} = {3'b100, 42'h0};
    {failures, n_compared, cyc} = 0;
    seed_v = $urandom(32'hD5D7);
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    host.rd(1'b1, v, t);
    chk(v, stat_w(CFG_RESET, 4'h4, 4'h4));
    $display("reset test ends");
    for (int i = 0; i < 6; i++) begin
      w = (i == 0) ? 16'hFFC0 : (i == 1) ? 16'hFFFF : 16'($urandom);
      host.wr(1'b1, w, 1'b0);
      host.rd(1'b1, v, t);
      chk(v, stat_w(w[5:0], 4'h4, 4'h4));
      chk(txa, !w[0]);
      chk(txb, !w[1]);
    end
    $display("config test ends");
    for (int i = 0; i < 8; i++) begin
      host.wr(1'b1, {10'h000, i[2], i[2], 4'hC}, 1'b0);
      @(posedge clk) sel <= i[1];
      w = 16'($urandom);
      host.wr(1'b0, w, i[0]);
      chk(tx.word, w);
      chk({tx.bus_b, tx.cmd_sync}, {i[1] | i[2], i[0] | i[2]});
    end
    host.wr(1'b1, 16'h000C, 1'b0);
    $display("transmit test ends");
    for (int b = 0; b < 2; b++) begin
      w = 16'($urandom);
      s = 1'($urandom);
      @(posedge clk) sel <= b[0];
      pulse(b[0], {4'h8, s}, w);
      chk(b ? rdyb : rdya, 1'b1);
      host.rd(1'b1, v, t);
      chk(v, b ? stat_w(CFG_RESET, {3'b010, sa}, {2'b01, s, 1'b1}) : stat_w(CFG_RESET, {2'b01, s, 1'b1}, 4'h4));
      if (b == 0) sa = s;
      host.rd(1'b0, v, t);
      chk(v, w);
      chk(t, s);
      chk(b ? rdyb : rdya, 1'b0);
    end
    @(posedge clk) sel <= 1'b0;
    $display("receive test ends");
    w = 16'($urandom);
    pulse(1'b0, 5'h10, 16'hA5A5);
    pulse(1'b0, 5'h11, w);
    chk(rdya, 1'b1);
    pulse(1'b0, 5'h08, 16'h0000);
    chk(rdya, 1'b0);
    host.rd(1'b0, v, t);
    chk(v, w);
    host.wr(1'b1, 16'h0000, 1'b0);
    pulse(1'b0, 5'h10, 16'h0F0F);
    pulse(1'b1, 5'h10, 16'h0F0F);
    chk({rdya, rdyb}, 2'b00);
    host.rd(1'b0, v, t);
    chk(v, w);
    host.wr(1'b1, 16'h000C, 1'b0);
    $display("overwrite test ends");
    pulse(1'b0, 5'h02, 16'h0000);
    chk(err, 1'b1);
    @(posedge clk) rx_a.active <= 1'b1;
    host.rd(1'b1, v, t);
    chk(v, stat_w(CFG_RESET, 4'hA, {2'b01, s, 1'b0}));
    @(posedge clk) rx_a.active <= 1'b0;
    @(posedge clk) mr <= 1'b1;
    @(posedge clk) mr <= 1'b0;
    host.rd(1'b0, v, t);
    chk(v, 16'h0000);
    host.rd(1'b1, v, t);
    chk(v, stat_w(CFG_RESET, 4'h4, 4'h4));
    $display("fault and reset test ends");
    print_verdict();
  end
endmodule // testbench
`default_nettype wire

/* design/sam_bank.sv */
// Purpose: status and mode register bank of a dual-bus smart transceiver
// Assumes: host pins synchronous to clock_i; encoder and decoders sit outside
// Notes:   the master reset pin acts like srst_i; transmit-ready bit reads 0 here
`timescale 1ns/1ps
`default_nettype none
module sam_bank (
  // clock and reset
  input  wire logic               clock_i,
  input  wire logic               srst_i,
  input  wire logic               master_reset_pin_i,
  // host strobed port
  input  wire logic               strb_n_i,
  input  wire logic               rd_wr_i,
  input  wire logic               reg_sel_i,
  input  wire logic [15:0]        data_i,
  output logic      [15:0]        data_o,
  output logic                    data_oe_n_o,
  // sync pin, two-way
  input  wire logic               sync_i,
  output logic                    sync_o,
  output logic                    sync_oe_n_o,
  // bus select pin
  input  wire logic               bus_select_pin_i,
  // decoder reports
  input  wire sam_pkg::sam_rx_t   rx_a_i,
  input  wire sam_pkg::sam_rx_t   rx_b_i,
  // encoder request and enables
  output sam_pkg::sam_tx_t        tx_o,
  output logic                    tx_enable_a_o,
  output logic                    tx_enable_b_o,
  // status pins
  output logic                    word_ready_a_o,
  output logic                    word_ready_b_o,
  output logic                    error_o
);
  import sam_pkg::*;

  // ****************************************************************
  // local signals
  // ****************************************************************
  logic                 rst;
  logic [CFG_W-1:0]     cfg_reg;
  logic                 wr_sam;
  logic                 wr_tx;
  logic                 rd_drive;
  logic                 rd_data_end;
  logic                 sel_b;
  logic                 cmd_sync;
  logic [15:0]          status_mode_word;
  logic [15:0]          rd_data_reg;
  logic                 rd_sync_reg;
  logic                 rd_sync_en_reg;
  logic [1:0]           read_clear;
  logic [1:0]           rx_enable;
  sam_stat_t            stat [2];
  logic [15:0]          hold [2];
  sam_rx_t              rx   [2];

  // master reset pulse does the same as the system reset
  assign rst = srst_i | master_reset_pin_i;

  // ****************************************************************
  // host strobe decoding
  // ****************************************************************
  sam_host_port u_port (
    .clock_i       (clock_i),
    .srst_i        (rst),
    .strb_n_i      (strb_n_i),
    .rd_wr_i       (rd_wr_i),
    .reg_sel_i     (reg_sel_i),
    .wr_sam_o      (wr_sam),
    .wr_tx_o       (wr_tx),
    .rd_drive_o    (rd_drive),
    .rd_data_end_o (rd_data_end)
  );

  // ****************************************************************
  // writable configuration bits
  // ****************************************************************
  // upper bits are status only, so a write simply never reaches them
  always_ff @(posedge clock_i) begin
    if (rst) begin
      cfg_reg <= CFG_RESET;
    end else if (wr_sam) begin
      cfg_reg <= data_i[CFG_W-1:0];
    end
  end

  // pin and bit ORed so either software or hardware may steer
  assign sel_b    = cfg_reg[BIT_BUS_SEL] | bus_select_pin_i;
  assign cmd_sync = cfg_reg[BIT_TX_SYNC] | sync_i;

  // ****************************************************************
  // per-bus receive status
  // ****************************************************************
  assign rx[0]        = rx_a_i;
  assign rx[1]        = rx_b_i;
  assign rx_enable[0] = cfg_reg[BIT_RX_EN_A];
  assign rx_enable[1] = cfg_reg[BIT_RX_EN_B];

  // read-clear goes only to the bus that the select picked
  assign read_clear[0] = rd_data_end & ~sel_b;
  assign read_clear[1] = rd_data_end & sel_b;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_bus
      // hold word stays until the next good word replaces it
      sam_rx_status u_rx (
        .clock_i      (clock_i),
        .srst_i       (rst),
        .rx_enable_i  (rx_enable[g]),
        .read_clear_i (read_clear[g]),
        .rx_i         (rx[g]),
        .stat_o       (stat[g]),
        .hold_o       (hold[g])
      );
    end
  endgenerate

  // ****************************************************************
  // status and mode word assembly
  // ****************************************************************
  always_comb begin
    status_mode_word                            = 16'h0000;
    status_mode_word[CFG_W-1:0]                 = cfg_reg;
    status_mode_word[BIT_UNUSED]                = 1'b0;
    status_mode_word[BIT_STAT_A +: 4]           = stat[0];
    status_mode_word[BIT_STAT_B +: 4]           = stat[1];
  end

  // ****************************************************************
  // read data path
  // ****************************************************************
  // data comes from flops; register select picks word, else the hold of the chosen bus
  always_ff @(posedge clock_i) begin
    if (rst) begin
      rd_data_reg <= 16'h0000;
    end else if (reg_sel_i) begin
      rd_data_reg <= status_mode_word;
    end else if (sel_b) begin
      rd_data_reg <= hold[1];
    end else begin
      rd_data_reg <= hold[0];
    end
  end

  // sync pin carries the stored sync of the hold being read
  always_ff @(posedge clock_i) begin
    if (rst) begin
      rd_sync_reg    <= 1'b0;
      rd_sync_en_reg <= 1'b0;
    end else begin
      rd_sync_reg    <= sel_b ? stat[1].sync : stat[0].sync;
      rd_sync_en_reg <= ~reg_sel_i;
    end
  end

  // pins driven only while a read strobe is low; enables active low
  assign data_o      = rd_data_reg;
  assign data_oe_n_o = ~rd_drive;
  assign sync_o      = rd_sync_reg;
  assign sync_oe_n_o = ~(rd_drive & rd_sync_en_reg & ~reg_sel_i);

  // ****************************************************************
  // transmit request to the encoder
  // ****************************************************************
  // select and sync captured at the write so later pin changes do not matter
  always_ff @(posedge clock_i) begin
    if (rst) begin
      tx_o <= '0;
    end else begin
      tx_o.load <= wr_tx;
      if (wr_tx) begin
        tx_o.word     <= data_i;
        tx_o.bus_b    <= sel_b;
        tx_o.cmd_sync <= cmd_sync;
      end
    end
  end

  // disabled transmitter still accepts words; only its output is cut
  always_ff @(posedge clock_i) begin
    if (rst) begin
      tx_enable_a_o <= 1'b1;
      tx_enable_b_o <= 1'b1;
    end else begin
      tx_enable_a_o <= ~cfg_reg[BIT_TX_DIS_A];
      tx_enable_b_o <= ~cfg_reg[BIT_TX_DIS_B];
    end
  end

  // ****************************************************************
  // status pins
  // ****************************************************************
  assign word_ready_a_o = stat[0].ready;
  assign word_ready_b_o = stat[1].ready;
  assign error_o        = stat[0].fault | stat[1].fault;
endmodule // sam_bank
`default_nettype wire

/* design/sam_host_port.sv */
// Purpose: decode host strobe cycles into one-cycle access events and a read drive level
// Assumes: strobe, direction and select are synchronous to clock_i
// Notes:   a cycle acts at the first low strobe sample; read-clear acts at release
`timescale 1ns/1ps
`default_nettype none
module sam_host_port (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic srst_i,
  // host pins
  input  wire logic strb_n_i,
  input  wire logic rd_wr_i,
  input  wire logic reg_sel_i,
  // decoded events
  output logic      wr_sam_o,
  output logic      wr_tx_o,
  output logic      rd_drive_o,
  output logic      rd_data_end_o
);
  import sam_pkg::*;

  logic strb_low_reg;
  logic rd_wr_reg;
  logic reg_sel_reg;

  // ****************************************************************
  // strobe history
  // ****************************************************************
  // the cycle kind is frozen at the falling edge so a late pin change cannot retarget the clear
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      strb_low_reg <= 1'b0;
      rd_wr_reg    <= 1'b1;
      reg_sel_reg  <= 1'b0;
    end else begin
      strb_low_reg <= ~strb_n_i;
      if (~strb_n_i && ~strb_low_reg) begin
        rd_wr_reg   <= rd_wr_i;
        reg_sel_reg <= reg_sel_i;
      end
    end
  end

  // writes act on the first low sample
  assign wr_sam_o      = ~strb_n_i & ~strb_low_reg & ~rd_wr_i & reg_sel_i;
  assign wr_tx_o       = ~strb_n_i & ~strb_low_reg & ~rd_wr_i & ~reg_sel_i;
  // reads drive the pins for the whole low phase
  assign rd_drive_o    = ~strb_n_i & rd_wr_i;
  // data read ends when strobe returns high
  assign rd_data_end_o = strb_n_i & strb_low_reg & rd_wr_reg & ~reg_sel_reg;
endmodule // sam_host_port
`default_nettype wire

/* design/sam_pkg.sv */
// Purpose: shared constants and carriers for the status and mode register bank
// Assumes: 16-bit host word, one 20 MHz clock
// Notes:   field positions, reset values and widths live here only
package sam_pkg;

  // ****************************************************************
  // word geometry
  // ****************************************************************
  localparam int unsigned DATA_W = 16;

  // ****************************************************************
  // status and mode word field positions
  // ****************************************************************
  localparam int unsigned BIT_TX_DIS_A  = 0;
  localparam int unsigned BIT_TX_DIS_B  = 1;
  localparam int unsigned BIT_RX_EN_A   = 2;
  localparam int unsigned BIT_RX_EN_B   = 3;
  localparam int unsigned BIT_TX_SYNC   = 4;
  localparam int unsigned BIT_BUS_SEL   = 5;
  localparam int unsigned BIT_UNUSED    = 6;
  localparam int unsigned BIT_STAT_A    = 7;   // first of ready, sync, idle, fault for bus A
  localparam int unsigned BIT_STAT_B    = 11;  // same group for bus B
  localparam int unsigned CFG_W         = 6;   // writable bits 0..5

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [5:0]  CFG_RESET     = 6'h0C;  // both receivers enabled
  localparam logic [15:0] HOLD_RESET    = 16'h0000;

  // ****************************************************************
  // carriers
  // ****************************************************************
  // one decoder's report for a bus
  typedef struct packed {
    logic              valid;   // one-cycle pulse, good word decoded
    logic              start;   // one-cycle pulse, new word begins
    logic              active;  // level, traffic seen on the bus
    logic              err;     // one-cycle pulse, bad encoding
    logic              sync;    // sync of the decoded word, 1 = command
    logic [15:0]       word;
  } sam_rx_t;

  // status nibble of one bus, in field order
  typedef struct packed {
    logic fault;
    logic idle;
    logic sync;
    logic ready;
  } sam_stat_t;

  // word handed to the encoder
  typedef struct packed {
    logic              load;     // one-cycle pulse
    logic              bus_b;    // 0 = bus A, 1 = bus B
    logic              cmd_sync; // 1 = command sync, 0 = data sync
    logic [15:0]       word;
  } sam_tx_t;

endpackage

/* design/sam_rx_status.sv */
// Purpose: receive hold word and status nibble for one bus
// Assumes: decoder pulses are one cycle wide
// Notes:   a new word always wins over a host read-clear in the same cycle
`timescale 1ns/1ps
`default_nettype none
module sam_rx_status (
  // clock and reset
  input  wire logic                clock_i,
  input  wire logic                srst_i,
  // control
  input  wire logic                rx_enable_i,
  input  wire logic                read_clear_i,
  // decoder report
  input  wire sam_pkg::sam_rx_t    rx_i,
  // state
  output sam_pkg::sam_stat_t       stat_o,
  output logic [15:0]              hold_o
);
  import sam_pkg::*;

  logic take_word;
  logic take_start;
  logic take_err;
  logic sync_reg;
  logic ready_reg;
  logic idle_reg;
  logic fault_reg;

  // disabled receiver sees nothing at all
  assign take_word  = rx_enable_i & rx_i.valid;
  assign take_start = rx_enable_i & rx_i.start;
  assign take_err   = rx_enable_i & rx_i.err;

  // ****************************************************************
  // hold word and last sync
  // ****************************************************************
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      hold_o   <= HOLD_RESET;
      sync_reg <= 1'b0;
    end else if (take_word) begin
      hold_o   <= rx_i.word;
      sync_reg <= rx_i.sync;
    end
  end

  // ****************************************************************
  // ready flag: set wins over both clears
  // ****************************************************************
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ready_reg <= 1'b0;
    end else if (take_word) begin
      ready_reg <= 1'b1;
    end else if (read_clear_i || take_start) begin
      ready_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // idle and fault
  // ****************************************************************
  // fault holds until the next word starts, so a host poll can still see it
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      idle_reg  <= 1'b0;
      fault_reg <= 1'b0;
    end else begin
      idle_reg <= ~(rx_enable_i & rx_i.active);
      if (take_err) begin
        fault_reg <= 1'b1;
      end else if (take_start) begin
        fault_reg <= 1'b0;
      end
    end
  end

  // one driver for the whole nibble, fields in status word order
  assign stat_o = {fault_reg, idle_reg, sync_reg, ready_reg};
endmodule // sam_rx_status
`default_nettype wire
